/* File: adcr_pkg.sv */
// Shared constants, field layouts and types of the converter control block.
package adcr_pkg;

   // ***************************************************************
   // Bus geometry
   // ***************************************************************
   localparam int             AXI_ADDR_W = 12;
   localparam int             AXI_DATA_W = 32;
   localparam logic [1:0]     RESP_OKAY   = 2'b00;
   localparam logic [1:0]     RESP_SLVERR = 2'b10;

   // ***************************************************************
   // Register indices and byte addresses
   // ***************************************************************
   localparam logic [11:0]    IDX_RESULT_LOW  = 12'h06F;
   localparam logic [11:0]    IDX_RESULT_HIGH = 12'h070;
   localparam logic [11:0]    IDX_CSR         = 12'h071;
   localparam logic [11:0]    ADDR_RESULT_LOW  = IDX_RESULT_LOW << 2;
   localparam logic [11:0]    ADDR_RESULT_HIGH = IDX_RESULT_HIGH << 2;
   localparam logic [11:0]    ADDR_CSR         = IDX_CSR << 2;

   // ***************************************************************
   // Control/status field positions
   // ***************************************************************
   localparam int             BIT_DONE       = 7;
   localparam int             BIT_FAST_CLOCK = 6;
   localparam int             BIT_ON         = 5;
   localparam int             BIT_DIVIDER    = 4;
   localparam int             BIT_SPARE      = 3;
   localparam int             CHAN_LSB       = 0;
   localparam int             CHAN_W         = 3;
   localparam int             RESULT_W       = 10;
   localparam int             HIGH_LSB       = 2;

   typedef struct packed {
      logic                   done;
      logic                   fast_clock;
      logic                   converter_on;
      logic                   divider;
      logic                   spare;
      logic [CHAN_W-1:0]      channel_select;
   } adcr_csr_t;

   // ***************************************************************
   // Reset values and result limits
   // ***************************************************************
   localparam logic [7:0]     RST_CSR         = 8'h00;
   localparam logic [7:0]     RST_RESULT_HIGH = 8'h00;
   localparam logic [1:0]     RST_RESULT_LOW  = 2'h0;
   localparam logic [9:0]     RESULT_FULL     = 10'h3FF;
   localparam logic [9:0]     RESULT_ZERO     = 10'h000;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int             CPU_CLOCK_HZ       = 50_000_000;
   localparam int             FAST_CLOCK_MAX_HZ  = 4_000_000;
   localparam int             DIV_W              = 4;
   localparam logic [3:0]     DIV_UNITY          = 4'h1;
   localparam logic [3:0]     DIV_MID_DEFAULT    = 4'h2;
   localparam logic [3:0]     DIV_SLOW_DEFAULT   = 4'h4;
   localparam int             TICK_W             = 5;
   localparam logic [4:0]     CONV_TICKS_DEFAULT = 5'h0E;

endpackage

/* File: adcr_conv_seq.sv */
// Conversion sequencer: converter clock divider and per-conversion tick count.
`timescale 1ns/1ps
module adcr_conv_seq #(
   parameter int DIV_W  = 4,
   parameter int TICK_W = 5
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   // Control
   input  wire logic              run,
   input  wire logic [DIV_W-1:0]  div_ratio,
   input  wire logic [TICK_W-1:0] conv_ticks,
   // Events
   output logic                   sample_pulse,
   output logic                   done_pulse
);

   logic [DIV_W-1:0]  div_cnt_r;
   logic [TICK_W-1:0] tick_cnt_r;
   logic              tick;
   logic              last_tick;

   // Ratio read live, so clock bits must settle before run rises
   assign tick      = run && (div_cnt_r == div_ratio - DIV_W'(1));
   assign last_tick = tick && (tick_cnt_r == conv_ticks - TICK_W'(1));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_r <= '0;
      end else if (!run || tick) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + DIV_W'(1);
      end
   end

   // Wraps and starts the next conversion while run holds [RL11]
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= '0;
      end else if (!run || last_tick) begin
         tick_cnt_r <= '0;
      end else if (tick) begin
         tick_cnt_r <= tick_cnt_r + TICK_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sample_pulse <= 1'b0;
         done_pulse   <= 1'b0;
      end else begin
         sample_pulse <= tick && (tick_cnt_r == '0);
         done_pulse   <= last_tick;
      end
   end

endmodule // adcr_conv_seq

/* File: adcr_regs.sv */
// Converter control/status and result registers behind an AXI4-Lite slave.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
// Functional notes
// [RL1] Hardware sets the done flag, bit 7 of control/status, when a conversion ends.
// [RL2] A read of the high result or any write of control/status clears the done flag; here only a write with byte lane 0 strobed clears it.
// [RL3] Every control/status bit is read/write except bit 7, which ignores writes.
// [RL4] Divider bit 0 with fast-clock bit 1 runs the converter at the CPU clock, for slow CPUs only.
// [RL5] Software settles both clock selection bits before it sets the converter-on bit.
// [RL6] Converter-on bit 5 low stops conversion, and setting it starts conversion.
// [RL7] Channel select in bits 2:0 picks input 0 to 5 in binary order.
// [RL8] The high result register shows result bits 9:2.
// [RL9] The low result register shows result bits 1:0 and reads zero above them.
// [RL10] Control/status and both result registers reset to zero.
// [RL11] While enabled the selected channel is converted over and over, each result stored.
// [RL12] A low result read freezes the high result until the high result is read.
// [RL13] An input above the upper reference stores full scale without any overflow mark.
// [RL14] The other clock bit combinations divide the CPU clock by set ratios.
module adcr_regs #(
   parameter logic [3:0] DIV_MID    = adcr_pkg::DIV_MID_DEFAULT,
   parameter logic [3:0] DIV_SLOW   = adcr_pkg::DIV_SLOW_DEFAULT,
   parameter logic [4:0] CONV_TICKS = adcr_pkg::CONV_TICKS_DEFAULT
) (
   // Clock and reset
   input  wire logic                                ref_clk,
   input  wire logic                                arst_n,
   // AXI4-Lite write address and data
   input  wire logic [adcr_pkg::AXI_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                                s_axi_awvalid,
   output logic                                     s_axi_awready,
   input  wire logic [adcr_pkg::AXI_DATA_W-1:0]     s_axi_wdata,
   input  wire logic [3:0]                          s_axi_wstrb,
   input  wire logic                                s_axi_wvalid,
   output logic                                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                               s_axi_bresp,
   output logic                                     s_axi_bvalid,
   input  wire logic                                s_axi_bready,
   // AXI4-Lite read
   input  wire logic [adcr_pkg::AXI_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                                s_axi_arvalid,
   output logic                                     s_axi_arready,
   output logic [adcr_pkg::AXI_DATA_W-1:0]          s_axi_rdata,
   output logic [1:0]                               s_axi_rresp,
   output logic                                     s_axi_rvalid,
   input  wire logic                                s_axi_rready,
   // Analog core
   input  wire logic [adcr_pkg::RESULT_W-1:0]       analog_data,
   input  wire logic                                analog_over_range,
   input  wire logic                                analog_under_range,
   output logic [adcr_pkg::CHAN_W-1:0]              analog_channel,
   output logic                                     analog_enable,
   output logic                                     analog_sample
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   adcr_pkg::adcr_csr_t                    csr_r;
   logic [7:0]                             res_high_r;
   logic [1:0]                             res_low_r;
   logic                                   lock_r;
   logic                                   aw_held_r;
   logic                                   w_held_r;
   logic [adcr_pkg::AXI_ADDR_W-1:0]        waddr_r;
   logic [adcr_pkg::AXI_DATA_W-1:0]        wdata_r;
   logic [3:0]                             wstrb_r;
   logic                                   do_write;
   logic                                   wr_csr;
   logic                                   wr_hit;
   logic                                   rd_fire;
   logic                                   rd_high_fire;
   logic                                   rd_low_fire;
   logic                                   rd_hit;
   logic [adcr_pkg::AXI_DATA_W-1:0]        rdata_nxt;
   logic [adcr_pkg::DIV_W-1:0]             div_ratio;
   logic [adcr_pkg::RESULT_W-1:0]          result_in;
   logic                                   conv_done;
   logic                                   sample_pulse;

   // ***************************************************************
   // Write channel
   // ***************************************************************
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_hit   = (waddr_r == adcr_pkg::ADDR_CSR) ||
                     (waddr_r == adcr_pkg::ADDR_RESULT_HIGH) ||
                     (waddr_r == adcr_pkg::ADDR_RESULT_LOW);
   // Byte lane 0 carries the whole register; other lanes are ignored
   assign wr_csr   = do_write && (waddr_r == adcr_pkg::ADDR_CSR) && wstrb_r[0];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held_r     <= 1'b0;
         waddr_r       <= '0;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r     <= 1'b1;
         waddr_r       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_held_r     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         w_held_r     <= 1'b0;
         wdata_r      <= '0;
         wstrb_r      <= '0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r     <= 1'b1;
         wdata_r      <= s_axi_wdata;
         wstrb_r      <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_held_r     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= adcr_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? adcr_pkg::RESP_OKAY : adcr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***************************************************************
   // Read channel
   // ***************************************************************
   assign rd_fire      = s_axi_arvalid && s_axi_arready;
   assign rd_high_fire = rd_fire && (s_axi_araddr == adcr_pkg::ADDR_RESULT_HIGH);
   assign rd_low_fire  = rd_fire && (s_axi_araddr == adcr_pkg::ADDR_RESULT_LOW);
   assign rd_hit       = rd_high_fire || rd_low_fire ||
                         (s_axi_araddr == adcr_pkg::ADDR_CSR);

   always_comb begin
      rdata_nxt = '0;
      unique case (s_axi_araddr)
         adcr_pkg::ADDR_CSR:         rdata_nxt[7:0] = csr_r;
         adcr_pkg::ADDR_RESULT_HIGH: rdata_nxt[7:0] = res_high_r;     // [RL8]
         adcr_pkg::ADDR_RESULT_LOW:  rdata_nxt[1:0] = res_low_r;      // [RL9]
         default:                    rdata_nxt      = '0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= adcr_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rdata_nxt;
         s_axi_rresp   <= rd_hit ? adcr_pkg::RESP_OKAY : adcr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   // ***************************************************************
   // Control/status register
   // ***************************************************************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         csr_r.fast_clock     <= adcr_pkg::RST_CSR[adcr_pkg::BIT_FAST_CLOCK];   // [RL10]
         csr_r.converter_on   <= adcr_pkg::RST_CSR[adcr_pkg::BIT_ON];
         csr_r.divider        <= adcr_pkg::RST_CSR[adcr_pkg::BIT_DIVIDER];
         csr_r.spare          <= adcr_pkg::RST_CSR[adcr_pkg::BIT_SPARE];
         csr_r.channel_select <= adcr_pkg::RST_CSR[adcr_pkg::CHAN_LSB +: adcr_pkg::CHAN_W];
      end else if (wr_csr) begin
         // Done bit is not taken from write data [RL3]
         csr_r.fast_clock     <= wdata_r[adcr_pkg::BIT_FAST_CLOCK];
         csr_r.converter_on   <= wdata_r[adcr_pkg::BIT_ON];              // [RL6]
         csr_r.divider        <= wdata_r[adcr_pkg::BIT_DIVIDER];
         csr_r.spare          <= wdata_r[adcr_pkg::BIT_SPARE];
         csr_r.channel_select <= wdata_r[adcr_pkg::CHAN_LSB +: adcr_pkg::CHAN_W];
      end
   end

   // Set beats clear so a conversion ending during a read is not lost
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         csr_r.done <= adcr_pkg::RST_CSR[adcr_pkg::BIT_DONE];
      end else if (conv_done) begin
         csr_r.done <= 1'b1;                                                 // [RL1]
      end else if (wr_csr || rd_high_fire) begin
         csr_r.done <= 1'b0;                                                 // [RL2]
      end
   end

   // ***************************************************************
   // Converter clock and sequencing
   // ***************************************************************
   always_comb begin
      if (csr_r.fast_clock && !csr_r.divider) begin
         div_ratio = adcr_pkg::DIV_UNITY;                                    // [RL4]
      end else if (csr_r.divider) begin
         div_ratio = DIV_SLOW;                                               // [RL14]
      end else begin
         div_ratio = DIV_MID;                                                // [RL14]
      end
   end

   // Clock bits take effect live; a change while running garbles one conversion [RL5]
   adcr_conv_seq #(
      .DIV_W  (adcr_pkg::DIV_W),
      .TICK_W (adcr_pkg::TICK_W)
   ) u_seq (
      .ref_clk      (ref_clk),
      .arst_n       (arst_n),
      .run          (csr_r.converter_on),                                    // [RL6]
      .div_ratio    (div_ratio),
      .conv_ticks   (CONV_TICKS),
      .sample_pulse (sample_pulse),
      .done_pulse   (conv_done)
   );

   // Channel code goes straight to the input mux [RL7]
   assign analog_channel = csr_r.channel_select;
   assign analog_enable  = csr_r.converter_on;
   assign analog_sample  = sample_pulse;

   // ***************************************************************
   // Result registers
   // ***************************************************************
   always_comb begin
      if (analog_over_range) begin
         result_in = adcr_pkg::RESULT_FULL;                                  // [RL13]
      end else if (analog_under_range) begin
         result_in = adcr_pkg::RESULT_ZERO;
      end else begin
         result_in = analog_data;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_r <= 1'b0;
      end else if (rd_low_fire) begin
         lock_r <= 1'b1;                                                     // [RL12]
      end else if (rd_high_fire) begin
         lock_r <= 1'b0;
      end
   end

   // Low half keeps updating; software reads it first, so pairs still match
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         res_high_r <= adcr_pkg::RST_RESULT_HIGH;                            // [RL10]
         res_low_r  <= adcr_pkg::RST_RESULT_LOW;
      end else if (conv_done) begin
         res_low_r  <= result_in[adcr_pkg::HIGH_LSB-1:0];                    // [RL9] [RL11]
         if (!lock_r) begin
            res_high_r <= result_in[adcr_pkg::RESULT_W-1:adcr_pkg::HIGH_LSB]; // [RL8] [RL12]
         end
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   property p_done_set;
      conv_done |=> csr_r.done;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set"); // [RL1]

   property p_done_clr_rd;
      rd_high_fire && !conv_done |=> !csr_r.done;
   endproperty
   a_done_clr_rd: assert property (p_done_clr_rd) else $error("done kept on read"); // [RL2]

   property p_done_clr_wr;
      wr_csr && !conv_done |=> !csr_r.done && s_axi_bvalid;
   endproperty
   a_done_clr_wr: assert property (p_done_clr_wr) else $error("done kept on write"); // [RL2]

   property p_csr_write;
      wr_csr |=> csr_r[6:0] == $past(wdata_r[6:0]);
   endproperty
   a_csr_write: assert property (p_csr_write) else $error("csr bits not written"); // [RL3]

   property p_unity;
      csr_r.fast_clock && !csr_r.divider |-> div_ratio == adcr_pkg::DIV_UNITY;
   endproperty
   a_unity: assert property (p_unity) else $error("fast setting not unity"); // [RL4]

   property p_stop;
      !csr_r.converter_on |=> !conv_done && !analog_sample;
   endproperty
   a_stop: assert property (p_stop) else $error("conversion while off"); // [RL6]

   property p_chan;
      wr_csr |=> analog_channel == $past(wdata_r[2:0]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel not applied"); // [RL7]

   property p_high_rd;
      rd_high_fire |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(res_high_r)};
   endproperty
   a_high_rd: assert property (p_high_rd) else $error("high read wrong"); // [RL8]

   property p_low_rd;
      rd_low_fire |=> s_axi_rdata == {30'h0, $past(res_low_r)};
   endproperty
   a_low_rd: assert property (p_low_rd) else $error("low read wrong"); // [RL9]

   property p_cont;
      $rose(csr_r.converter_on) ##1 csr_r.converter_on[*8] |-> ##[0:200] conv_done;
   endproperty
   a_cont: assert property (p_cont) else $error("no conversion while on"); // [RL11]

   property p_freeze;
      lock_r && !rd_high_fire |=> $stable(res_high_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("high result moved"); // [RL12]

   property p_sat;
      conv_done && analog_over_range && !lock_r |=>
         res_high_r == 8'hFF && res_low_r == 2'h3;
   endproperty
   a_sat: assert property (p_sat) else $error("no full scale"); // [RL13]

   c_done:    cover property (conv_done ##[1:300] conv_done);
   c_pair:    cover property (rd_low_fire ##[1:50] rd_high_fire);
   c_sat:     cover property (conv_done && analog_over_range);
   c_collide: cover property (conv_done && (wr_csr || rd_high_fire));

endmodule // adcr_regs

/* File: testbench.sv */
// Self-checking bench for the converter control and result registers.
`timescale 1ns/1ps
module testbench;
   localparam logic [3:0] DM = 4'h2;
   localparam logic [3:0] DS = 4'h4;
   localparam logic [4:0] CT = 5'h0E;
   logic        ref_clk = 1'b0;
   logic        arst_n  = 1'b0;
   logic [11:0] awaddr  = 12'h000;
   logic [11:0] araddr  = 12'h000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic [31:0] rd, rdata;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [9:0]  adata   = 10'h000;
   logic        over    = 1'b0, under = 1'b0;
   logic [2:0]  achan;
   logic        aen, asmp;
   int          errors  = 0, n_checks = 0, n, m_res;
   int          q_res   [$];
   logic [31:0] seed    = 32'h9F96;
   logic [7:0]  clk_set [3] = '{8'h60, 8'h20, 8'h30};
   int          ratio   [3] = '{1, DM, DS};
   always #10 ref_clk = ~ref_clk;
   adcr_regs #(.DIV_MID(DM), .DIV_SLOW(DS), .CONV_TICKS(CT)) uut (
      .ref_clk(ref_clk), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .analog_data(adata), .analog_over_range(over), .analog_under_range(under),
      .analog_channel(achan), .analog_enable(aen), .analog_sample(asmp));
   // ***************************************************************
   // Bus tasks and helpers
   // ***************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [11:0] a);
      @(posedge ref_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask
   // Polls the done flag; a csr read has no side effect on it
   task automatic wait_done;
      rd = 32'h0;
      for (int i = 0; i < 200 && rd[7] !== 1'b1; i++) rdr(adcr_pkg::ADDR_CSR);
   endtask
   // Cycles between two conversion starts
   task automatic period(output int p);
      p = 0;
      while (asmp !== 1'b1 && p < 600) begin
         @(posedge ref_clk);
         p++;
      end
      p = 0;
      do begin
         @(posedge ref_clk);
         p++;
      end while (asmp !== 1'b1 && p < 600);
   endtask
   task automatic report_and_stop;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      rdr(adcr_pkg::ADDR_RESULT_LOW);
      chk(rd, 32'h0);
      rdr(adcr_pkg::ADDR_RESULT_HIGH);
      chk(rd, 32'h0);
      rdr(adcr_pkg::ADDR_CSR);
      chk(rd, 32'h0);
      rdr(12'hFFC);
      chk({30'h0, rsp}, {30'h0, adcr_pkg::RESP_SLVERR});
      wr(adcr_pkg::ADDR_CSR, 32'hDF);
      chk({30'h0, rsp}, {30'h0, adcr_pkg::RESP_OKAY});
      rdr(adcr_pkg::ADDR_CSR);
      chk(rd, 32'h5F);
      $display("test reset and access done");
      // Clock bits settle with the converter off, then it is switched on
      for (int ch = 0; ch < 6; ch++) begin
         seed = lfsr(seed);
         adata <= seed[9:0];
         m_res = seed[9:0];
         wr(adcr_pkg::ADDR_CSR, 32'h40 | ch);
         wr(adcr_pkg::ADDR_CSR, 32'h60 | ch);
         chk({29'h0, achan}, ch);
         chk({31'h0, aen}, 32'h1);
         wait_done;
         chk({31'h0, rd[7]}, 32'h1);
         rdr(adcr_pkg::ADDR_RESULT_LOW);
         chk(rd, m_res & 3);
         rdr(adcr_pkg::ADDR_RESULT_HIGH);
         chk(rd, m_res >> 2);
      end
      $display("test channels done");
      for (int k = 0; k < 3; k++) begin
         wr(adcr_pkg::ADDR_CSR, {24'h0, clk_set[k] & 8'hDF});
         wr(adcr_pkg::ADDR_CSR, {24'h0, clk_set[k]});
         period(n);
         chk(n, CT * ratio[k]);
      end
      $display("test clock ratios done");
      // Fresh done flag on slow clock leaves room to read before the next result
      wr(adcr_pkg::ADDR_CSR, 32'h30);
      wait_done;
      rdr(adcr_pkg::ADDR_RESULT_HIGH);
      rdr(adcr_pkg::ADDR_CSR);
      chk({31'h0, rd[7]}, 32'h0);
      wait_done;
      rdr(adcr_pkg::ADDR_RESULT_LOW);
      q_res.push_back(m_res);
      seed = lfsr(seed);
      adata <= seed[9:0];
      m_res = seed[9:0];
      repeat (3 * CT * DS) @(posedge ref_clk);
      rdr(adcr_pkg::ADDR_RESULT_LOW);
      chk(rd, m_res & 3);
      rdr(adcr_pkg::ADDR_RESULT_HIGH);
      chk(rd, q_res.pop_front() >> 2);
      wr(adcr_pkg::ADDR_CSR, 32'h30);
      wait_done;
      rdr(adcr_pkg::ADDR_RESULT_HIGH);
      chk(rd, m_res >> 2);
      $display("test lock done");
      for (int k = 0; k < 2; k++) begin
         over <= (k == 0);
         under <= (k == 1);
         wr(adcr_pkg::ADDR_CSR, 32'h30);
         wait_done;
         rdr(adcr_pkg::ADDR_RESULT_LOW);
         chk(rd, (k == 0) ? 32'h03 : 32'h00);
         rdr(adcr_pkg::ADDR_RESULT_HIGH);
         chk(rd, (k == 0) ? 32'hFF : 32'h00);
      end
      $display("test range done");
      wr(adcr_pkg::ADDR_CSR, 32'h10);
      chk({31'h0, aen}, 32'h0);
      n = 0;
      repeat (200) begin
         @(posedge ref_clk);
         if (asmp !== 1'b0) n++;
      end
      chk(n, 0);
      // A conversion ending with the stop may set done; clear it once idle
      wr(adcr_pkg::ADDR_CSR, 32'h10);
      rdr(adcr_pkg::ADDR_CSR);
      chk(rd, 32'h10);
      $display("test disable done");
      report_and_stop;
   end
   // Whole run needs about a thousand cycles
   initial begin
      #1_000_000;
      errors++;
      report_and_stop;
   end
endmodule // testbench
